// [rtl/ddr_fe_pkg.sv]
// Constants for the command, address and clock-gate front end.
// Assumes one clock domain at 100 MHz; no register bus.
package ddr_fe_pkg;
  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_ROW_OPEN = 3'h3;
  localparam logic [2:0] CMD_BANK_CLOSE = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_MODE_WRITE = 3'h0;
  // Address field positions
  localparam int AP_BIT = 10;
  localparam int UPPER_COL_BIT = 11;
  localparam int EXT_BANK = 1;
  localparam int DLL_DIS_BIT = 0;
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  // Mode field encodings
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [2:0] CL_2P5 = 3'h6;
  // Reset values
  localparam logic [2:0] BL_RESET = 3'h1;
  localparam logic [2:0] CL_RESET = 3'h2;
  // Self refresh internal interval (7.8 us per row at 8192 rows / 64 ms)
  localparam int SELF_REF_NS = 7800;
  localparam int CLK_NS = 10;
  localparam int SELF_REF_CYC = SELF_REF_NS / CLK_NS;
  // Burst count helpers
  localparam int BEATS_MAX = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BURST = 3'h1,
    ST_SELF_REF = 3'h2,
    ST_POWER_DN = 3'h3
  } fe_state_t;
endpackage

// [rtl/ddr_cmd_front_end.sv]
// Command, address and clock-gate front end of a four-bank DDR memory.
// Assumes the controller drives link pins sampled here through two flops.
`timescale 1ns/100ps
`default_nettype none
module ddr_cmd_front_end #(
  parameter int SELF_REF_CYCLES = ddr_fe_pkg::SELF_REF_CYC
) (
  // Clock, reset, freeze
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Link pins from the controller
  input wire logic link_clk,
  input wire logic clk_gate,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic bank_sel_lo,
  input wire logic bank_sel_hi,
  input wire logic [12:0] addr_lines,
  input wire logic [1:0] write_byte_mask,
  // Configuration strap
  input wire logic wide_cfg,
  // Access outputs to the array
  output logic [3:0] bank_open,
  output logic [12:0] row_addr,
  output logic [1:0] acc_bank,
  output logic [10:0] acc_col,
  output logic acc_valid,
  output logic acc_write,
  output logic acc_edge,
  output logic [1:0] byte_keep,
  output logic rd_data_valid,
  // Mode and status
  output logic [2:0] burst_len,
  output logic burst_ilv,
  output logic [2:0] read_lat,
  output logic dll_on,
  output logic self_ref,
  output logic power_dn,
  output logic refresh_pulse
);

  // =========================================================
  // Pin synchronisers
  // =========================================================
  localparam int PW = 23;
  logic [PW-1:0] pin_raw, sync1_r, sync2_r;
  logic lclk_d_r;
  assign pin_raw = {link_clk, clk_gate, chip_sel_n, row_strobe_n, col_strobe_n,
    write_en_n, bank_sel_hi, bank_sel_lo, addr_lines, write_byte_mask};

  // Two flops on every pin before use
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      lclk_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      lclk_d_r <= sync2_r[22];
    end
  end

  logic s_lclk, s_gate, s_cs_n, rise, fall;
  logic [2:0] s_cmd;
  logic [1:0] s_bank, s_mask;
  logic [12:0] s_addr;
  assign s_lclk = sync2_r[22];
  assign s_gate = sync2_r[21];
  assign s_cs_n = sync2_r[20];
  assign s_cmd = sync2_r[19:17];
  assign s_bank = sync2_r[16:15];
  assign s_addr = sync2_r[14:2];
  assign s_mask = sync2_r[1:0];
  assign rise = s_lclk && !lclk_d_r;
  assign fall = !s_lclk && lclk_d_r;

  // =========================================================
  // State
  // =========================================================
  typedef struct packed {
    ddr_fe_pkg::fe_state_t st;
    logic gate_q, wr, ap, valid, edge_hi, rdv, ilv, dll, ref_p;
    logic [3:0] open, beats_left, lat_cnt;
    logic [12:0] rows;
    logic [1:0] bank, keep;
    logic [10:0] col, base;
    logic [2:0] beat, bl, cl;
    logic [15:0] sr_cnt;
  } fe_state_s_t;

  fe_state_s_t cur_r;
  fe_state_s_t cur_nxt;

  // Burst beat length from the mode code
  function automatic logic [3:0] beats_of(input logic [2:0] code);
    case (code)
      ddr_fe_pkg::BL_4: beats_of = 4'h4;
      ddr_fe_pkg::BL_8: beats_of = 4'h8;
      default: beats_of = 4'h2;
    endcase
  endfunction

  // Column of a beat, sequential or interleaved within the burst
  function automatic logic [10:0] beat_col(input logic [10:0] base, input logic [2:0] beat,
    input logic [3:0] n, input logic ilv);
    logic [2:0] m;
    logic [2:0] off;
    m = 3'(n - 4'h1);
    off = ilv ? ((base[2:0] ^ beat) & m) : ((base[2:0] + beat) & m);
    beat_col = {base[10:3], (base[2:0] & ~m) | off};
  endfunction

  // Read latency in half clocks
  function automatic logic [3:0] lat_half(input logic [2:0] code);
    case (code)
      ddr_fe_pkg::CL_3: lat_half = 4'h6;
      ddr_fe_pkg::CL_2P5: lat_half = 4'h5;
      default: lat_half = 4'h4;
    endcase
  endfunction

  // Next state
  always_comb
  begin
    logic cmd_ok, half;
    cmd_ok = 1'b0;
    half = rise || fall;
    cur_nxt = cur_r;
    cur_nxt.ref_p = 1'b0;
    cur_nxt.valid = 1'b0; // Beat strobe lasts one cycle
    if (rise)
      cur_nxt.gate_q = s_gate;
    // Self refresh ticks on internal timing, without link edges
    if (cur_r.st == ddr_fe_pkg::ST_SELF_REF)
    begin
      if (cur_r.sr_cnt == 16'(SELF_REF_CYCLES - 1))
      begin
        cur_nxt.sr_cnt = 16'h0;
        cur_nxt.ref_p = 1'b1;
      end
      else
        cur_nxt.sr_cnt = cur_r.sr_cnt + 16'h1;
    end
    if (rise && !s_gate)
    begin
      // Gate low: the idle state goes to power down, or to self refresh on a refresh with all banks closed
      if (cur_r.st == ddr_fe_pkg::ST_IDLE && !s_cs_n && s_cmd == ddr_fe_pkg::CMD_REFRESH &&
        cur_r.open == 4'h0)
        cur_nxt.st = ddr_fe_pkg::ST_SELF_REF;
      else if (cur_r.st == ddr_fe_pkg::ST_IDLE)
        cur_nxt.st = ddr_fe_pkg::ST_POWER_DN;
    end
    else if (rise && s_gate && (cur_r.st == ddr_fe_pkg::ST_SELF_REF ||
      cur_r.st == ddr_fe_pkg::ST_POWER_DN))
    begin
      cur_nxt.st = ddr_fe_pkg::ST_IDLE;
      cur_nxt.sr_cnt = 16'h0;
    end
    // Clock suspended: burst counter, acc_col, byte_keep and rd_data_valid stay frozen
    if (cur_r.gate_q)
    begin
      if (half && cur_r.st == ddr_fe_pkg::ST_BURST)
      begin
        cur_nxt.valid = 1'b1;
        cur_nxt.edge_hi = rise;
        cur_nxt.col = beat_col(cur_r.base, cur_r.beat, beats_of(cur_r.bl), cur_r.ilv);
        cur_nxt.keep = cur_r.wr ? ~s_mask : 2'h3;
        cur_nxt.beat = cur_r.beat + 3'h1;
        cur_nxt.beats_left = cur_r.beats_left - 4'h1;
        if (cur_r.beats_left == 4'h1)
        begin
          cur_nxt.st = ddr_fe_pkg::ST_IDLE;
          if (cur_r.ap)
            cur_nxt.open[cur_r.bank] = 1'b0;
        end
      end
      if (half && cur_r.lat_cnt != 4'h0)
      begin
        cur_nxt.lat_cnt = cur_r.lat_cnt - 4'h1;
        cur_nxt.rdv = (cur_r.lat_cnt == 4'h1);
      end
      else if (half && cur_r.rdv && cur_r.st != ddr_fe_pkg::ST_BURST)
        cur_nxt.rdv = 1'b0;
      cmd_ok = rise && s_gate && !s_cs_n && cur_r.st != ddr_fe_pkg::ST_BURST;
    end
    if (cmd_ok)
    begin
      case (s_cmd)
        ddr_fe_pkg::CMD_ROW_OPEN:
        begin
          cur_nxt.open[s_bank] = 1'b1;
          cur_nxt.rows = s_addr;
        end
        ddr_fe_pkg::CMD_BANK_CLOSE:
          cur_nxt.open[s_bank] = 1'b0;
        ddr_fe_pkg::CMD_READ, ddr_fe_pkg::CMD_WRITE:
        begin
          // Access to a closed bank is the controller's fault and is dropped
          if (cur_r.open[s_bank])
          begin
            cur_nxt.st = ddr_fe_pkg::ST_BURST;
            cur_nxt.bank = s_bank;
            cur_nxt.base = {wide_cfg ? 1'b0 : s_addr[ddr_fe_pkg::UPPER_COL_BIT], s_addr[9:0]};
            cur_nxt.col = cur_nxt.base;
            cur_nxt.ap = s_addr[ddr_fe_pkg::AP_BIT];
            cur_nxt.wr = (s_cmd == ddr_fe_pkg::CMD_WRITE);
            cur_nxt.beat = 3'h0;
            cur_nxt.beats_left = beats_of(cur_r.bl);
            if (s_cmd == ddr_fe_pkg::CMD_READ)
              cur_nxt.lat_cnt = lat_half(cur_r.cl);
          end
        end
        ddr_fe_pkg::CMD_REFRESH:
          cur_nxt.ref_p = (cur_r.open == 4'h0);
        ddr_fe_pkg::CMD_MODE_WRITE:
        begin
          if (s_bank == 2'(ddr_fe_pkg::EXT_BANK))
            cur_nxt.dll = !s_addr[ddr_fe_pkg::DLL_DIS_BIT];
          else if (s_bank == 2'h0)
          begin
            cur_nxt.bl = s_addr[ddr_fe_pkg::BL_LSB +: 3];
            cur_nxt.ilv = s_addr[ddr_fe_pkg::BT_BIT];
            cur_nxt.cl = s_addr[ddr_fe_pkg::CL_LSB +: 3];
          end
        end
        default: ;
      endcase
    end
  end

  // Register the whole state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_r <= '0;
      cur_r.st <= ddr_fe_pkg::ST_IDLE;
      cur_r.gate_q <= 1'b1;
      cur_r.keep <= 2'h3;
      cur_r.bl <= ddr_fe_pkg::BL_RESET;
      cur_r.cl <= ddr_fe_pkg::CL_RESET;
      cur_r.dll <= 1'b1;
    end
    else if (clk_en)
      cur_r <= cur_nxt;
  end

  // Outputs
  assign {bank_open, row_addr, acc_bank} = {cur_r.open, cur_r.rows, cur_r.bank};
  assign {acc_col, acc_valid, acc_write} = {cur_r.col, cur_r.valid, cur_r.wr};
  assign {acc_edge, byte_keep, rd_data_valid} = {cur_r.edge_hi, cur_r.keep, cur_r.rdv};
  assign {burst_len, burst_ilv, read_lat, dll_on} = {cur_r.bl, cur_r.ilv, cur_r.cl, cur_r.dll};
  assign self_ref = (cur_r.st == ddr_fe_pkg::ST_SELF_REF);
  assign power_dn = (cur_r.st == ddr_fe_pkg::ST_POWER_DN);
  assign refresh_pulse = cur_r.ref_p;

  // =========================================================
  // Checks
  // =========================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // Extended mode write taken in this cycle
  logic cmd_fire_ext;
  assign cmd_fire_ext = rise && s_gate && cur_r.gate_q && !s_cs_n &&
    cur_r.st != ddr_fe_pkg::ST_BURST && s_cmd == ddr_fe_pkg::CMD_MODE_WRITE &&
    s_bank == 2'(ddr_fe_pkg::EXT_BANK);

  sequence seq_suspended;
    !cur_r.gate_q && clk_en;
  endsequence

  a_frozen_counter: assert property (seq_suspended |=> $stable(cur_r.beat))
    else $error("burst counter moved while suspended");
  a_gate_next: assert property (rise && clk_en |=> cur_r.gate_q == $past(s_gate))
    else $error("gate not taken at rising edge");
  a_cs_mask: assert property (clk_en && rise && s_cs_n && cur_r.st == ddr_fe_pkg::ST_IDLE
    |=> $stable(cur_r.open))
    else $error("command taken with chip select high");
  a_row_open: assert property (clk_en && rise && s_gate && cur_r.gate_q && !s_cs_n &&
    s_cmd == ddr_fe_pkg::CMD_ROW_OPEN && cur_r.st != ddr_fe_pkg::ST_BURST
    |=> cur_r.open[$past(s_bank)] && cur_r.rows == $past(s_addr))
    else $error("row open not captured");
  a_burst_len: assert property (clk_en && cur_r.st == ddr_fe_pkg::ST_BURST
    |-> cur_r.beats_left <= beats_of(cur_r.bl))
    else $error("burst longer than programmed");
  a_mask_keep: assert property (clk_en && cur_r.gate_q && (rise || fall) &&
    cur_r.st == ddr_fe_pkg::ST_BURST && cur_r.wr |=> byte_keep == ~$past(s_mask))
    else $error("write mask not applied");
  a_auto_close: assert property (clk_en && cur_r.gate_q && (rise || fall) &&
    cur_r.st == ddr_fe_pkg::ST_BURST && cur_r.beats_left == 4'h1 && cur_r.ap
    |=> !cur_r.open[cur_r.bank])
    else $error("auto precharge missed");
  a_dll_only: assert property (clk_en && !cmd_fire_ext |=> $stable(dll_on))
    else $error("dll changed without extended write");
  a_wide_col: assert property (wide_cfg && cur_r.st == ddr_fe_pkg::ST_BURST
    |-> !cur_r.col[10])
    else $error("bit eleven used in wide mode");
endmodule
`default_nettype wire

// [test/ddr_ctl_model.sv]
// Controller model: makes the link clock and drives command and mask pins.
// Assumes the front end samples commands on rising link edges and the byte mask on both link edges.
`timescale 1ns/100ps
`default_nettype none
module ddr_ctl_model (
  // Bench clock for drive timing
  input wire logic sys_clk,
  // Link pins toward the memory
  output logic link_clk,
  output logic clk_gate,
  output logic chip_sel_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_en_n,
  output logic bank_sel_lo,
  output logic bank_sel_hi,
  output logic [12:0] addr_lines,
  output logic [1:0] write_byte_mask
);
  // Free running controller clock, 160 ns
  initial
  begin
    link_clk = 1'b0;
    forever #80 link_clk = ~link_clk;
  end
  // Idle pins: gate high, no command
  initial
  begin
    clk_gate = 1'b1;
    {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
    {bank_sel_hi, bank_sel_lo} = 2'h0;
    addr_lines = 13'h0;
    write_byte_mask = 2'h0;
  end
  // One command set up half a link period before its rising edge
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a,
                     input logic cs_n, input logic [1:0] m, input logic g);
    @(negedge link_clk);
    @(negedge sys_clk);
    clk_gate <= g;
    chip_sel_n <= cs_n;
    {row_strobe_n, col_strobe_n, write_en_n} <= c;
    {bank_sel_hi, bank_sel_lo} <= ba;
    addr_lines <= a;
    write_byte_mask <= m;
    @(posedge link_clk);
    @(negedge link_clk);
    @(negedge sys_clk);
    // Released address shows no stale value
    {row_strobe_n, col_strobe_n, write_en_n} <= 3'h7;
    addr_lines <= ~a;
  endtask
  // Clock gate change between rising edges
  task automatic gate(input logic g);
    @(negedge link_clk);
    @(negedge sys_clk);
    clk_gate <= g;
  endtask
endmodule
`default_nettype wire

// [test/ddr_sdram_cmd_addr_front_end_test.sv]
// Testbench for the command front end, with a burst order model.
// Assumes the controller model and a 100 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module ddr_sdram_cmd_addr_front_end_test;
  logic sys_clk, nrst, clk_en, wide_cfg, link_clk, clk_gate, chip_sel_n;
  logic row_strobe_n, col_strobe_n, write_en_n, bank_sel_lo, bank_sel_hi;
  logic [12:0] addr_lines, row_addr;
  logic [1:0] write_byte_mask, acc_bank, byte_keep, keep_exp, bank_exp;
  logic [3:0] bank_open;
  logic [10:0] acc_col;
  logic [2:0] burst_len, read_lat;
  logic acc_valid, acc_write, acc_edge, rd_data_valid, burst_ilv, dll_on;
  logic self_ref, power_dn, refresh_pulse, rd_seen, wr_exp, edge_exp, edge_on;
  int err_count, n_checks, cycles, n_ref;
  int seen_q[$], exp_q[$];
  logic [2:0] bls[3] = '{ddr_fe_pkg::BL_2, ddr_fe_pkg::BL_4, ddr_fe_pkg::BL_8};
  logic [2:0] cls[3] = '{ddr_fe_pkg::CL_2, ddr_fe_pkg::CL_2P5, ddr_fe_pkg::CL_3};
  // Design and controller
  ddr_cmd_front_end #(.SELF_REF_CYCLES(8)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .clk_en(clk_en), .link_clk(link_clk), .clk_gate(clk_gate), .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
    .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi), .addr_lines(addr_lines),
    .write_byte_mask(write_byte_mask), .wide_cfg(wide_cfg), .bank_open(bank_open),
    .row_addr(row_addr), .acc_bank(acc_bank), .acc_col(acc_col), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_edge(acc_edge), .byte_keep(byte_keep),
    .rd_data_valid(rd_data_valid), .burst_len(burst_len), .burst_ilv(burst_ilv),
    .read_lat(read_lat), .dll_on(dll_on), .self_ref(self_ref), .power_dn(power_dn),
    .refresh_pulse(refresh_pulse));
  ddr_ctl_model ctl (.sys_clk(sys_clk), .link_clk(link_clk), .clk_gate(clk_gate),
    .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_en_n(write_en_n), .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi),
    .addr_lines(addr_lines), .write_byte_mask(write_byte_mask));
  // System clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Beat monitor, refresh counter and hang limit
  always @(negedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
    if (refresh_pulse === 1'b1)
      n_ref++;
    if (rd_data_valid === 1'b1)
      rd_seen = 1'b1;
    if (acc_valid === 1'b1)
    begin
      seen_q.push_back(int'(acc_col));
      chk({acc_bank, acc_write, byte_keep, acc_edge | ~edge_on},
          {bank_exp, wr_exp, keep_exp, edge_exp | ~edge_on});
      edge_exp = ~edge_exp;
    end
  end
  // One read or write burst checked against the order model
  task automatic access(input int b, input logic [12:0] a, input logic wr,
                        input logic [1:0] m, input int n, input logic ilv);
    int col;
    int off;
    col = int'({a[11] & ~wide_cfg, a[9:0]});
    off = col & (n - 1);
    exp_q = {};
    for (int i = 0; i < n; i++)
      exp_q.push_back((col & ~(n - 1)) | (ilv ? (off ^ i) : ((off + i) % n)));
    seen_q = {};
    rd_seen = 1'b0;
    edge_exp = 1'b0;
    wr_exp = wr;
    keep_exp = wr ? ~m : 2'h3;
    bank_exp = 2'(b);
    ctl.cmd(wr ? ddr_fe_pkg::CMD_WRITE : ddr_fe_pkg::CMD_READ, 2'(b), a, 1'b0, m, 1'b1);
    repeat (8) @(posedge link_clk);
    chk(32'(seen_q.size()), 32'(n));
    foreach (exp_q[i])
      chk(seen_q[i], exp_q[i]);
    if (!wr)
      chk(32'(rd_seen), 32'h1);
    chk(32'(bank_open[b]), 32'(!a[10]));
  endtask
  // Main sequence
  initial
  begin
    logic [12:0] a;
    int b;
    void'($urandom(32'h28bf49ed));
    {nrst, clk_en, wide_cfg, edge_on, edge_exp, wr_exp} = 6'h1c;
    keep_exp = 2'h3;
    bank_exp = 2'h0;
    repeat (2) @(posedge sys_clk);
    chk({byte_keep, burst_len, read_lat, dll_on, bank_open}, {2'h3, 3'h1, 3'h2, 1'b1, 4'h0});
    @(negedge sys_clk) nrst <= 1'b1;
    // Every burst length, type and latency; open, read, write with precharge
    for (int k = 0; k < 3; k++)
      for (int t = 0; t < 2; t++)
      begin
        b = $urandom_range(3);
        a = 13'($urandom);
        ctl.cmd(ddr_fe_pkg::CMD_MODE_WRITE, 2'h0, {6'($urandom), cls[k], t[0], bls[k]}, 1'b0,
                2'($urandom), 1'b1);
        wide_cfg <= t[0];
        chk({burst_len, burst_ilv, read_lat}, {bls[k], t[0], cls[k]});
        ctl.cmd(ddr_fe_pkg::CMD_ROW_OPEN, 2'(b), a, 1'b0, 2'($urandom), 1'b1);
        chk({bank_open, row_addr}, {4'h1 << b, a});
        access(b, a & 13'h1bff, 1'b0, 2'($urandom), 2 << k, t[0]);
        access(b, a | 13'h0400, 1'b1, 2'($urandom), 2 << k, t[0]);
      end
    // Command with chip select high is ignored
    ctl.cmd(ddr_fe_pkg::CMD_ROW_OPEN, 2'($urandom), a, 1'b1, 2'($urandom), 1'b1);
    chk(bank_open, 4'h0);
    // Burst frozen by the clock gate; last mode is eight, interleaved
    ctl.cmd(ddr_fe_pkg::CMD_ROW_OPEN, 2'h2, a, 1'b0, 2'h0, 1'b1);
    edge_on = 1'b0;
    fork
      access(2, a & 13'h1bff, 1'b0, 2'($urandom), 8, 1'b1);
      begin
        repeat (2) @(posedge link_clk);
        ctl.gate(1'b0);
        repeat (2) @(posedge link_clk);
        ctl.gate(1'b1);
      end
    join
    // Power down with a row active, then close the bank
    ctl.gate(1'b0);
    repeat (3) @(posedge link_clk);
    chk({power_dn, bank_open}, {1'b1, 4'h4});
    ctl.gate(1'b1);
    repeat (3) @(posedge link_clk);
    chk(power_dn, 1'b0);
    ctl.cmd(ddr_fe_pkg::CMD_BANK_CLOSE, 2'h2, a, 1'b0, 2'h0, 1'b1);
    chk(bank_open, 4'h0);
    // Precharged power down
    ctl.gate(1'b0);
    repeat (3) @(posedge link_clk);
    chk(power_dn, 1'b1);
    ctl.gate(1'b1);
    repeat (3) @(posedge link_clk);
    // Delay-locked loop off and on again
    ctl.cmd(ddr_fe_pkg::CMD_MODE_WRITE, 2'h1, 13'h0001, 1'b0, 2'h0, 1'b1);
    chk(dll_on, 1'b0);
    ctl.cmd(ddr_fe_pkg::CMD_MODE_WRITE, 2'h1, 13'h0000, 1'b0, 2'h0, 1'b1);
    chk(dll_on, 1'b1);
    // Clock enable low freezes all state: a row open in that time is lost
    clk_en <= 1'b0;
    ctl.cmd(ddr_fe_pkg::CMD_ROW_OPEN, 2'($urandom), a, 1'b0, 2'($urandom), 1'b1);
    chk({bank_open, power_dn, dll_on}, {4'h0, 1'b0, 1'b1});
    clk_en <= 1'b1;
    // Auto refresh, then self refresh timed inside
    n_ref = 0;
    ctl.cmd(ddr_fe_pkg::CMD_REFRESH, 2'h0, a, 1'b0, 2'($urandom), 1'b1);
    chk(n_ref, 1);
    ctl.cmd(ddr_fe_pkg::CMD_REFRESH, 2'h0, a, 1'b0, 2'h0, 1'b0);
    chk(self_ref, 1'b1);
    n_ref = 0;
    repeat (80) @(posedge sys_clk);
    chk(32'(n_ref >= 9 && n_ref <= 11), 32'h1);
    ctl.gate(1'b1);
    repeat (3) @(posedge link_clk);
    chk(self_ref, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
